// ===== hdl/actr_regs.svh
`ifndef ACTR_REGS_SVH
`define ACTR_REGS_SVH
// register indices on the 8-bit port
`define ACTR_OFS_MAIN        3'h0
`define ACTR_OFS_FMT         3'h1
`define ACTR_OFS_TRIG        3'h2
`define ACTR_OFS_RESH        3'h3
`define ACTR_OFS_RESL        3'h4
`define ACTR_OFS_PIR         3'h5
// field positions
`define ACTR_TRIG_MSB        7
`define ACTR_TRIG_LSB        4
`define ACTR_MAIN_GO         1
`define ACTR_MAIN_EN         0
`define ACTR_FMT_JUSTIFY     7
`define ACTR_PIR_IRQ         0
// reset values and write masks
`define ACTR_TRIG_RST        8'h00
`define ACTR_TRIG_MASK       8'hf0
// busy bit masked: software starts only beside the enable bit
`define ACTR_MAIN_MASK       8'h7d
`define ACTR_FMT_MASK        8'hf7
`define ACTR_MAIN_RST        8'h00
`define ACTR_FMT_RST         8'h00
// conversion length in clock cycles
`define ACTR_CONV_CYCLES     16'd44
`endif

// ===== hdl/actr_pkg.sv
package actr_pkg;
	typedef struct packed {
		logic       capture_unit_1;
		logic       capture_unit_2;
		logic       tmr0_wrap;
		logic       tmr1_wrap;
		logic       tmr2_period;
		logic       tmr4_period;
		logic       tmr6_period;
		logic       cmp1_synced;
		logic       cmp2_synced;
		logic [3:0] logic_cell;
	} actr_events_t;
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} actr_bus_t;
	typedef enum logic [3:0] {
		TRIG_NONE, TRIG_CAPTURE_UNIT_1, TRIG_CAPTURE_UNIT_2, TRIG_T0, TRIG_T1, TRIG_T2,
		TRIG_C1, TRIG_C2, TRIG_LC1, TRIG_LC2, TRIG_LC3, TRIG_LC4,
		TRIG_T4, TRIG_T6, TRIG_RSV0, TRIG_RSV1
	} actr_trig_t;
	typedef enum logic [1:0] {
		CONV_IDLE, CONV_RUN, CONV_LOAD
	} actr_conv_t;
endpackage

// ===== hdl/actr_edge_sel.sv
`timescale 1ns/100ps
// picks one event by code and pulses on its rising edge
module actr_edge_sel
	import actr_pkg::*;
(
	input  wire logic         clock_in,
	input  wire logic         rst_n_in,
	input  wire actr_pkg::actr_events_t events_in,
	input  wire logic [3:0]   sel_in,
	output logic              edge_out
);
	import actr_pkg::*;

	// ----------------------------------------
	// source mux
	// ----------------------------------------
	function automatic logic pick(input actr_events_t e, input logic [3:0] s);
		case (actr_trig_t'(s))
			TRIG_CAPTURE_UNIT_1: pick = e.capture_unit_1;
			TRIG_CAPTURE_UNIT_2: pick = e.capture_unit_2;
			TRIG_T0:   pick = e.tmr0_wrap;
			TRIG_T1:   pick = e.tmr1_wrap;
			TRIG_T2:   pick = e.tmr2_period;
			TRIG_C1:   pick = e.cmp1_synced;
			TRIG_C2:   pick = e.cmp2_synced;
			TRIG_LC1:  pick = e.logic_cell[0];
			TRIG_LC2:  pick = e.logic_cell[1];
			TRIG_LC3:  pick = e.logic_cell[2];
			TRIG_LC4:  pick = e.logic_cell[3];
			TRIG_T4:   pick = e.tmr4_period;
			TRIG_T6:   pick = e.tmr6_period;
			default:   pick = 1'b0; // none and reserved codes never fire
		endcase
	endfunction

	wire logic selected = pick(events_in, sel_in);
	logic      last;

	// ----------------------------------------
	// edge detect
	// ----------------------------------------
	// a code change resets the history so the new source's level is not an edge
	logic [3:0] last_code;
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			last      <= 1'b0;
			last_code <= 4'h0;
			edge_out  <= 1'b0;
		end
		else
		begin
			last      <= selected;
			last_code <= sel_in;
			edge_out  <= selected && !last && (last_code == sel_in);
		end
	end
endmodule

// ===== hdl/actr_top.sv
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/100ps
`include "actr_regs.svh"
//
// Contract
// - trigger code sits in bits 7..4 of the trigger select register
// - code 0 starts nothing; 1 and 2 pick capture units 1 and 2
// - code 3 picks timer0 wrap, code 4 timer1 wrap
// - codes 5, 12, 13 pick timer2, timer4, timer6 period events
// - codes 6 and 7 pick synced comparator 1 and 2 outputs
// - codes 8 to 11 pick logic cells 1 to 4
// - only a rising edge of the chosen source triggers
// - timer wrap used as trigger still sets the timer's own flag
// - low nibble of trigger select reads zero
// - trigger select resets to zero on every reset
// - left justified: high register holds result bits 9..2
// - left justified: low register holds bits 1..0 in bits 7..6
// - right justified: high register holds bits 9..8 in bits 1..0
// - right justified: low register holds result bits 7..0
// - result registers read/write, untouched by reset
// - held sample is never cleared between conversions
// - trigger edge sets the busy bit like a software start
// - busy bit clears at end; software set together with the enable bit starts a conversion
// - format bit 1 right, 0 left; unused bits load as zero
module actr_top
	import actr_pkg::*;
#(
	parameter logic [15:0] CONV_CYCLES = `ACTR_CONV_CYCLES
)
(
	input  wire logic         clock_in,
	input  wire logic         rst_n_in,
	input  wire actr_pkg::actr_bus_t    bus_in,
	output logic [7:0]        rdata_out,
	input  wire actr_pkg::actr_events_t events_in,
	input  wire logic [9:0]   sample_in,
	output logic [4:0]        channel_out,
	output logic              enable_out,
	output logic              busy_out,
	output logic              sample_hold_out,
	output logic              irq_flag_out,
	output logic              tmr0_flag_set_out,
	output logic              tmr1_flag_set_out
);
	import actr_pkg::*;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0]  conv_trigger_select;
	logic [7:0]  conv_control_main;
	logic [7:0]  conv_control_format_clock;
	logic [7:0]  conv_result_high;
	logic [7:0]  conv_result_low;
	logic        conversion_irq_flag;
	logic [15:0] count;
	actr_conv_t  state;
	logic        trig_edge;
	logic        tmr0_last;
	logic        tmr1_last;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire logic wr_main = bus_in.wr && bus_in.addr == `ACTR_OFS_MAIN;
	wire logic wr_fmt  = bus_in.wr && bus_in.addr == `ACTR_OFS_FMT;
	wire logic wr_trig = bus_in.wr && bus_in.addr == `ACTR_OFS_TRIG;
	wire logic wr_resh = bus_in.wr && bus_in.addr == `ACTR_OFS_RESH;
	wire logic wr_resl = bus_in.wr && bus_in.addr == `ACTR_OFS_RESL;
	wire logic wr_pir  = bus_in.wr && bus_in.addr == `ACTR_OFS_PIR;
	wire logic enabled = conv_control_main[`ACTR_MAIN_EN];
	wire logic busy    = conv_control_main[`ACTR_MAIN_GO];
	wire logic right_j = conv_control_format_clock[`ACTR_FMT_JUSTIFY];
	wire logic sw_go   = wr_main && bus_in.wdata[`ACTR_MAIN_GO];
	wire logic hw_go   = trig_edge && enabled;
	wire logic done    = state == CONV_LOAD;

	// unused bits are zero in the loaded result
	wire logic [7:0] load_high = right_j ? {6'h00, sample_in[9:8]}
	                                     : sample_in[9:2];
	wire logic [7:0] load_low  = right_j ? sample_in[7:0]
	                                     : {sample_in[1:0], 6'h00};

	wire logic [7:0] rd_mux =
		(bus_in.addr == `ACTR_OFS_MAIN) ? conv_control_main :
		(bus_in.addr == `ACTR_OFS_FMT)  ? conv_control_format_clock :
		(bus_in.addr == `ACTR_OFS_TRIG) ? (conv_trigger_select & `ACTR_TRIG_MASK) :
		(bus_in.addr == `ACTR_OFS_RESH) ? conv_result_high :
		(bus_in.addr == `ACTR_OFS_RESL) ? conv_result_low :
		(bus_in.addr == `ACTR_OFS_PIR)  ? {7'h00, conversion_irq_flag} :
		8'h00;

	// ----------------------------------------
	// trigger selection and edge
	// ----------------------------------------
	actr_edge_sel u_edge
	(
		.clock_in  (clock_in),
		.rst_n_in  (rst_n_in),
		.events_in (events_in),
		.sel_in    (conv_trigger_select[`ACTR_TRIG_MSB:`ACTR_TRIG_LSB]),
		.edge_out  (trig_edge)
	);

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			conv_trigger_select <= `ACTR_TRIG_RST;
		else if (wr_trig)
			conv_trigger_select <= bus_in.wdata & `ACTR_TRIG_MASK;
	end

	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			conv_control_format_clock <= `ACTR_FMT_RST;
		else if (wr_fmt)
			conv_control_format_clock <= bus_in.wdata & `ACTR_FMT_MASK;
	end

	// software cannot clear a running conversion's busy bit by writing zero
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			conv_control_main <= `ACTR_MAIN_RST;
		else
		begin
			if (wr_main)
				conv_control_main <= (bus_in.wdata & `ACTR_MAIN_MASK) | {6'h00, busy, 1'b0};
			if (hw_go || (sw_go && bus_in.wdata[`ACTR_MAIN_EN]))
				conv_control_main[`ACTR_MAIN_GO] <= 1'b1;
			else if (done)
				conv_control_main[`ACTR_MAIN_GO] <= 1'b0;
		end
	end

	// ----------------------------------------
	// conversion sequencer
	// ----------------------------------------
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state <= CONV_IDLE;
			count <= 16'h0000;
		end
		else
		begin
			case (state)
				CONV_IDLE:
					if (busy && enabled)
					begin
						state <= CONV_RUN;
						count <= CONV_CYCLES;
					end
				CONV_RUN:
					if (!enabled)
						state <= CONV_IDLE;
					else if (count <= 16'h0001)
						state <= CONV_LOAD;
					else
						count <= count - 16'h0001;
				CONV_LOAD:
					state <= CONV_IDLE;
				default:
					state <= CONV_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// result registers, no reset
	// ----------------------------------------
	// contents survive reset; hardware load wins over a same-cycle write
	always_ff @(posedge clock_in)
	begin
		if (done)
		begin
			conv_result_high <= load_high;
			conv_result_low  <= load_low;
		end
		else
		begin
			if (wr_resh)
				conv_result_high <= bus_in.wdata;
			if (wr_resl)
				conv_result_low <= bus_in.wdata;
		end
	end

	// ----------------------------------------
	// flags and outputs
	// ----------------------------------------
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			conversion_irq_flag <= 1'b0;
		else if (done)
			conversion_irq_flag <= 1'b1;
		else if (wr_pir)
			conversion_irq_flag <= bus_in.wdata[`ACTR_PIR_IRQ];
	end

	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rdata_out         <= 8'h00;
			channel_out       <= 5'h00;
			enable_out        <= 1'b0;
			busy_out          <= 1'b0;
			sample_hold_out   <= 1'b0;
			irq_flag_out      <= 1'b0;
			tmr0_last         <= 1'b0;
			tmr1_last         <= 1'b0;
			tmr0_flag_set_out <= 1'b0;
			tmr1_flag_set_out <= 1'b0;
		end
		else
		begin
			rdata_out         <= bus_in.rd ? rd_mux : 8'h00;
			channel_out       <= conv_control_main[6:2];
			enable_out        <= enabled;
			busy_out          <= busy;
			// hold asserted while converting; no discharge phase between
			sample_hold_out   <= state == CONV_RUN;
			irq_flag_out      <= conversion_irq_flag;
			tmr0_last         <= events_in.tmr0_wrap;
			tmr1_last         <= events_in.tmr1_wrap;
			// timer flags are raised whatever the trigger selection
			tmr0_flag_set_out <= events_in.tmr0_wrap && !tmr0_last;
			tmr1_flag_set_out <= events_in.tmr1_wrap && !tmr1_last;
		end
	end
endmodule

// ===== tb/actr_evt_model.sv
`timescale 1ns/100ps
module actr_evt_model
	import actr_pkg::*;
(
	input	wire logic			clock_in,
	input	wire logic			rst_n_in,
	input	wire logic [3:0]		code_in,
	input	wire logic			go_in,
	output	actr_pkg::actr_events_t		events_out
);
	// struct bit per code; 15 shifts out, so no source moves
	localparam logic [3:0] POS [16] = '{4'hf, 4'hc, 4'hb, 4'ha, 4'h9, 4'h8, 4'h5, 4'h4,
		4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'h6, 4'hf, 4'hf};
	logic [7:0]	left;
	// held as a level well past the conversion, so level sensing would show
	always_ff @(posedge clock_in or negedge rst_n_in)
		if (!rst_n_in)
			left <= 8'h00;
		else if (go_in)
			left <= 8'h28;
		else if (left != 8'h00)
			left <= left - 8'h01;
	assign events_out = (left != 8'h00) ? actr_events_t'(13'h1 << POS[code_in]) : '0;
endmodule

// ===== tb/actr_properties.sv
`timescale 1ns/100ps
module actr_checker
	import actr_pkg::*;
#(
	parameter logic [15:0] CONV_CYCLES = 16'h002c
)
(
	input	wire logic			clock_in,
	input	wire logic			rst_n_in,
	input	wire actr_pkg::actr_bus_t	bus_in,
	input	wire logic [7:0]		rdata_out,
	input	wire actr_pkg::actr_events_t	events_in,
	input	wire logic			busy_out,
	input	wire logic [4:0]		channel_out,
	input	wire logic			enable_out,
	input	wire logic			sample_hold_out,
	input	wire logic			irq_flag_out,
	input	wire logic			tmr0_flag_set_out,
	input	wire logic			tmr1_flag_set_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	logic [15:0]	run;
	logic		trig_w;
	// busy length is too long to unroll as a repetition
	always_ff @(posedge clock_in or negedge rst_n_in)
		if (!rst_n_in)
			run <= 16'h0;
		else
			run <= busy_out ? run + 16'h1 : 16'h0;
	always_ff @(posedge clock_in or negedge rst_n_in)
		if (!rst_n_in)
			trig_w <= 1'b0;
		else if (bus_in.wr && bus_in.addr == 3'h2)
			trig_w <= 1'b1;
	sequence s_rd(a);
		$past(bus_in.rd) && $past(bus_in.addr) == a;
	endsequence
	sequence s_end;
		$fell(busy_out);
	endsequence
	AST_TRIG_LOW: assert property (s_rd(3'h2) |-> rdata_out[3:0] == 4'h0)
		else $error("trigger low nibble set");
	AST_TRIG_RST: assert property (s_rd(3'h2) ##0 !trig_w |-> rdata_out == 8'h00)
		else $error("trigger select not reset");
	AST_RUN_LEN: assert property (s_end |->
		run > CONV_CYCLES && run < CONV_CYCLES + 16'h4) else $error("bad busy length");
	AST_DONE_IRQ: assert property (s_end |-> ##[0:2] irq_flag_out)
		else $error("no irq flag at end");
	AST_HOLD: assert property (sample_hold_out |-> busy_out)
		else $error("hold without busy");
	AST_T0_FLAG: assert property ($rose(events_in.tmr0_wrap) |-> ##[1:2] tmr0_flag_set_out)
		else $error("timer0 flag missed");
	AST_T1_FLAG: assert property ($rose(events_in.tmr1_wrap) |-> ##[1:2] tmr1_flag_set_out)
		else $error("timer1 flag missed");
	AST_FLAG_PULSE: assert property ((tmr0_flag_set_out |=> !tmr0_flag_set_out) and
		(tmr1_flag_set_out |=> !tmr1_flag_set_out)) else $error("timer flag too long");
	AST_MAIN_OUT: assert property (bus_in.wr && bus_in.addr == 3'h0 |-> ##2
		channel_out == $past(bus_in.wdata[6:2], 2) && enable_out == $past(bus_in.wdata[0], 2))
		else $error("main register outputs wrong");
endmodule
bind actr_top actr_checker #(.CONV_CYCLES(CONV_CYCLES)) u_checker (.*);

// ===== tb/tb_adc_trigger_and_result_regs.sv
`timescale 1ns/100ps
module tb_adc_trigger_and_result_regs;
	import actr_pkg::*;
	logic		clock_in = 1'b0;
	logic		rst_n_in = 1'b0;
	actr_bus_t	bus = '0;
	actr_events_t	ev;
	logic [9:0]	smp = '0;
	logic [7:0]	rdata;
	logic [7:0]	q[$];
	logic [3:0]	code = '0;
	logic		go = 1'b0;
	logic		busy;
	logic		rd_d = 1'b0;
	int		n_errors = 0;
	int		n_compared = 0;
	int		c;
	actr_top #(.CONV_CYCLES(16'h0004)) u_dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
		.bus_in(bus), .rdata_out(rdata), .events_in(ev), .sample_in(smp), .channel_out(),
		.enable_out(), .busy_out(busy), .sample_hold_out(), .irq_flag_out(),
		.tmr0_flag_set_out(), .tmr1_flag_set_out());
	actr_evt_model u_src (.clock_in(clock_in), .rst_n_in(rst_n_in), .code_in(code),
		.go_in(go), .events_out(ev));
	always #12.5 clock_in = ~clock_in;
	task automatic chk(string n, logic [7:0] x, logic [7:0] s);
		n_compared++;
		if (s !== x)
		begin
			n_errors++;
			$display("mismatch %s exp %h got %h", n, x, s);
		end
	endtask
	// a read carries its expected value on d, noted for the monitor
	task automatic acc(logic w, logic [2:0] a, logic [7:0] d);
		@(posedge clock_in);
		bus <= '{a, d, w, !w};
		if (!w)
			q.push_back(d);
		@(posedge clock_in);
		bus <= '0;
	endtask
	always @(posedge clock_in)
	begin
		if (rd_d)
			chk("rdata", q.pop_front(), rdata);
		rd_d <= bus.rd;
	end
	task automatic waitb(logic v);
		for (int i = 0; i < 99 && busy !== v; i++)
			@(posedge clock_in);
		chk("busy", {7'h0, v}, {7'h0, busy});
	endtask
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		void'($urandom(32'hc7d9));
		repeat (3) @(posedge clock_in);
		rst_n_in <= 1'b1;
		acc(0, 3'h2, 8'h00);
		acc(0, 3'h7, 8'h00);
		acc(1, 3'h2, 8'hff);
		acc(0, 3'h2, 8'hf0);
		for (c = 0; c < 6; c++)
		begin
			smp <= 10'($urandom);
			acc(1, 3'h1, {c[0], 7'h00});
			acc(1, 3'h0, 8'h0d);
			repeat (8) @(posedge clock_in);
			acc(1, 3'h0, 8'h0f);
			waitb(1'b1);
			waitb(1'b0);
			acc(0, 3'h5, 8'h01);
			acc(1, 3'h5, 8'h00);
			acc(0, 3'h3, c[0] ? {6'h0, smp[9:8]} : smp[9:2]);
			acc(0, 3'h4, c[0] ? smp[7:0] : {smp[1:0], 6'h0});
		end
		$display("test conversion done");
		acc(1, 3'h3, 8'ha5);
		rst_n_in <= 1'b0;
		@(posedge clock_in);
		rst_n_in <= 1'b1;
		acc(0, 3'h3, 8'ha5);
		acc(0, 3'h2, 8'h00);
		acc(1, 3'h0, 8'h02);
		acc(0, 3'h0, 8'h00);
		$display("test reset done");
		acc(1, 3'h0, 8'h01);
		for (c = 0; c < 16; c++)
		begin
			acc(1, 3'h2, {c[3:0], 4'h0});
			repeat (3) @(posedge clock_in);
			code <= c[3:0];
			go <= 1'b1;
			@(posedge clock_in);
			go <= 1'b0;
			if (c > 0 && c < 14)
			begin
				waitb(1'b1);
				waitb(1'b0);
			end
			repeat (6) @(posedge clock_in);
			chk("busy", 8'h00, {7'h0, busy});
			repeat (40) @(posedge clock_in);
		end
		$display("test trigger done");
		end_sim();
	end
	initial
	begin
		repeat (9000) @(posedge clock_in);
		n_errors++;
		end_sim();
	end
endmodule
